// File: inc/gdcs_pkg.sv
/*
 * constants and types for the gas detector calibration sequencer.
 * assumes a 250 MHz core clock and a 12-bit converter sample stream.
 */
package gdcs_pkg;
  // ****************************************************************
  // clock and tick
  // ****************************************************************
  localparam int CLK_NS = 4;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  // ****************************************************************
  // times in milliseconds (tick units)
  // ****************************************************************
  localparam int MS_W = 20;
  localparam logic [19:0] HOLD_MS = 20'h00FA0;
  localparam logic [19:0] RED_FLASH_MS = 20'h00BB8;
  localparam logic [19:0] ZERO_STEADY_MS = 20'h00FA0;
  localparam logic [19:0] STABLE_MS = 20'h07530;
  localparam logic [19:0] O2_WAIT_MS = 20'h00BB8;
  localparam logic [19:0] BLINK_MS = 20'h000FA;
  localparam int ABORT_MIN = 12;
  localparam int MS_PER_MIN = 60000;
  localparam logic [19:0] ABORT_MS = 20'(ABORT_MIN * MS_PER_MIN);
  // ****************************************************************
  // converter scale
  // ****************************************************************
  localparam int ADC_W = 12;
  localparam logic [11:0] ADC_FULL = 12'hFFF;
  localparam int LOW_PCT = 4;
  localparam logic [11:0] LOW_THRESH = 12'((32'(ADC_FULL) * LOW_PCT) / 100);
  localparam logic [11:0] FAULT_THRESH = 12'h0AA;
  // ****************************************************************
  // calibration log
  // ****************************************************************
  localparam int STAMP_W = 32;
  localparam int LOG_DEPTH = 8;
  localparam int LOG_IW = 3;
  localparam logic [3:0] LOG_FULL = 4'h8;
  localparam logic [2:0] LOG_LAST = 3'h7;
  localparam logic [2:0] LOG_SECOND = 3'h1;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    SENS_COMB, SENS_TOXIC, SENS_O2, SENS_OPTICAL
  } gdcs_sensor_t;
  typedef enum logic [3:0] {
    S_IDLE, S_ZERO_STEADY, S_REP_ZERO, S_SPAN_WAIT, S_REP_SPAN,
    S_LOW_WAIT, S_O2_PRE, S_O2_POST
  } gdcs_state_t;
endpackage : gdcs_pkg

// File: inc/gdcs_log_if.sv
/*
 * carrier between the sequencer and its calibration log store.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface gdcs_log_if;
  logic wr;
  logic clr;
  logic [11:0] zero;
  logic [11:0] span;
  logic [31:0] stamp;
  logic [2:0] rd_idx;
  logic [11:0] rd_zero;
  logic [11:0] rd_span;
  logic [31:0] rd_stamp;
  logic [3:0] count;
  modport seq (output wr, clr, zero, span, stamp, rd_idx,
               input rd_zero, rd_span, rd_stamp, count);
  modport store (input wr, clr, zero, span, stamp, rd_idx,
                 output rd_zero, rd_span, rd_stamp, count);
endinterface : gdcs_log_if

// File: verilog/gdcs_cal_log.sv
/*
 * eight-entry calibration log; slot zero keeps the first entry.
 * assumes one write request per cycle at most from the sequencer.
 */
`timescale 1ns/1ps
module gdcs_cal_log (
  input wire logic core_clk,
  input wire logic rst_b,
  gdcs_log_if.store lg
);
  logic [11:0] ent_zero [gdcs_pkg::LOG_DEPTH];
  logic [11:0] ent_span [gdcs_pkg::LOG_DEPTH];
  logic [31:0] ent_stamp [gdcs_pkg::LOG_DEPTH];
  logic [3:0] cnt;
  logic [2:0] ptr;
  logic [2:0] wr_idx;
  logic [2:0] next_ptr;
  logic [3:0] next_cnt;

  // ****************************************************************
  // slot selection
  // ****************************************************************
  assign wr_idx = (lg.clr || cnt == 4'h0) ? 3'h0 : ptr;
  assign next_ptr = (lg.clr || cnt == 4'h0) ? gdcs_pkg::LOG_SECOND :
                    (ptr == gdcs_pkg::LOG_LAST) ? gdcs_pkg::LOG_SECOND :
                    3'(ptr + 3'h1);
  assign next_cnt = lg.clr ? 4'h1 :
                    (cnt == gdcs_pkg::LOG_FULL) ? cnt : 4'(cnt + 4'h1);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      ptr <= 3'h0;
    end else if (lg.wr) begin
      cnt <= next_cnt;
      ptr <= next_ptr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (lg.wr) begin
      ent_zero[wr_idx] <= lg.zero;
      ent_span[wr_idx] <= lg.span;
      ent_stamp[wr_idx] <= lg.stamp;
    end
  end

  assign lg.rd_zero = ent_zero[lg.rd_idx];
  assign lg.rd_span = ent_span[lg.rd_idx];
  assign lg.rd_stamp = ent_stamp[lg.rd_idx];
  assign lg.count = cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_keep_first;
    lg.wr && !lg.clr && cnt != 4'h0 |-> wr_idx != 3'h0;
  endproperty
  a_keep_first: assert property (p_keep_first)
    else $error("log append hit the first slot");
endmodule : gdcs_cal_log

// File: verilog/gdcs_sequencer.sv
/*
 * calibration sequencer for a detector_comm_unit: zero/span capture,
 * indicator control, abort timeout, fault suppression and log feed.
 * assumes converter samples, switches and button synchronous to core_clk.
 */
// Functional notes
// - start calibration after reed held 4 s; red flashes during first 3 s.
// - routine: flash until zero steady, capture zero, then indicator steady.
// - routine span wait: calibrate indicator flashes while gas above zero.
// - span input stable 30 s: capture span, indicator steady.
// - after span wait for input below 4% full scale, then finish, off.
// - routine not done in 12 min: abort, restore, red flash, log abort.
// - replacement mode suppresses the low-input fault.
// - replacement calibration never times out.
// - replacement button during calibration restarts from zero step.
// - replacement calibration writes its values into log slot one.
// - replacement: zero and span on separate reed holds, flash while rising.
// - oxygen routine: flash, wait 3 s, capture span, steady, wait 3 s, done.
// - optical replacement: flash for zero then follow routine flow.
// - each successful calibration logs zero, span and time stamp.
// - aborted calibration logs zero and span as zero.
// - log cleared only when a replacement calibration completes.
// - slot one kept; past eight entries overwrite the second-oldest.
// - sensor value is 12-bit counts, 0 for 0 mA, 4095 for 24 mA.
`timescale 1ns/1ps
module gdcs_sequencer #(
  parameter int TICK_DIV = gdcs_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] adc_sample,
  input wire logic adc_valid,
  input wire logic reed_sw,
  input wire logic replace_btn,
  input wire gdcs_pkg::gdcs_sensor_t sensor_type,
  input wire logic [11:0] stab_tol,
  input wire logic [31:0] stamp,
  input wire logic [2:0] log_rd_idx,
  output logic red_led,
  output logic cal_led,
  output logic fault,
  output logic [11:0] zero_val,
  output logic [11:0] span_val,
  output logic cal_active,
  output logic cal_done,
  output logic cal_abort,
  output logic [11:0] log_rd_zero,
  output logic [11:0] log_rd_span,
  output logic [31:0] log_rd_stamp,
  output logic [3:0] log_count
);
  gdcs_log_if lg ();

  function automatic logic in_band(input logic [11:0] a, input logic [11:0] b,
                                   input logic [11:0] tol);
    logic [11:0] d;
    d = (a > b) ? 12'(a - b) : 12'(b - a);
    return d <= tol;
  endfunction : in_band

  // ****************************************************************
  // millisecond tick and blink
  // ****************************************************************
  logic [31:0] tick_cnt;
  logic tick;
  logic [19:0] blink_ms;
  logic blink;
  assign tick = tick_cnt == 32'(TICK_DIV - 1);

  always_ff @(posedge core_clk) begin
    if (!rst_b || tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= 32'(tick_cnt + 32'h1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      blink_ms <= 20'h0;
      blink <= 1'b0;
    end else if (tick) begin
      blink_ms <= (blink_ms == 20'(gdcs_pkg::BLINK_MS - 20'h1)) ? 20'h0 :
                  20'(blink_ms + 20'h1);
      blink <= (blink_ms == 20'(gdcs_pkg::BLINK_MS - 20'h1)) ? ~blink : blink;
    end
  end

  // ****************************************************************
  // reed hold, button edge
  // ****************************************************************
  logic [19:0] reed_ms;
  logic reed_go;
  logic red_win;
  logic btn_prev;
  logic btn_rise;

  always_ff @(posedge core_clk) begin
    if (!rst_b || !reed_sw) begin
      reed_ms <= 20'h0;
    end else if (tick && reed_ms != gdcs_pkg::HOLD_MS) begin
      reed_ms <= 20'(reed_ms + 20'h1);
    end
  end

  assign reed_go = reed_sw && tick &&
                   reed_ms == 20'(gdcs_pkg::HOLD_MS - 20'h1);
  assign red_win = reed_sw && reed_ms < gdcs_pkg::RED_FLASH_MS;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      btn_prev <= 1'b0;
    end else begin
      btn_prev <= replace_btn;
    end
  end
  assign btn_rise = replace_btn && !btn_prev;

  // ****************************************************************
  // sample hold and stability timer
  // ****************************************************************
  logic [11:0] adc_hold;
  logic [11:0] stab_ref;
  logic [19:0] stab_ms;
  logic leave_band;
  logic gas_seen;
  assign leave_band = adc_valid && !in_band(adc_sample, stab_ref, stab_tol);
  assign gas_seen = adc_hold > zero_val &&
                    !in_band(adc_hold, zero_val, stab_tol);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      adc_hold <= 12'h000;
      stab_ref <= 12'h000;
      stab_ms <= 20'h0;
    end else begin
      if (adc_valid) begin
        adc_hold <= adc_sample;
      end
      if (leave_band) begin
        stab_ref <= adc_sample;
        stab_ms <= 20'h0;
      end else if (tick && stab_ms != gdcs_pkg::STABLE_MS) begin
        stab_ms <= 20'(stab_ms + 20'h1);
      end
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  gdcs_pkg::gdcs_state_t st;
  gdcs_pkg::gdcs_state_t next_st;
  logic rep_mode;
  logic abort_flash;
  logic [11:0] prev_zero;
  logic [11:0] prev_span;
  logic [19:0] abort_ms;
  logic [19:0] phase_ms;
  logic cap_zero;
  logic cap_span;
  logic finish;
  logic abort_hit;
  logic start;
  logic o2;

  assign o2 = sensor_type == gdcs_pkg::SENS_O2;
  assign abort_hit = st != gdcs_pkg::S_IDLE && !rep_mode &&
                     abort_ms >= gdcs_pkg::ABORT_MS;
  assign start = st == gdcs_pkg::S_IDLE && reed_go;

  always_comb begin
    next_st = st;
    cap_zero = 1'b0;
    cap_span = 1'b0;
    finish = 1'b0;
    case (st)
      gdcs_pkg::S_IDLE: begin
        if (reed_go) begin
          next_st = o2 ? gdcs_pkg::S_O2_PRE : gdcs_pkg::S_ZERO_STEADY;
        end
      end
      gdcs_pkg::S_ZERO_STEADY: begin
        if (stab_ms >= gdcs_pkg::ZERO_STEADY_MS) begin
          cap_zero = 1'b1;
          next_st = gdcs_pkg::S_SPAN_WAIT;
        end
      end
      gdcs_pkg::S_REP_ZERO: begin
        if (reed_go) begin
          cap_zero = 1'b1;
          next_st = gdcs_pkg::S_REP_SPAN;
        end
      end
      gdcs_pkg::S_SPAN_WAIT: begin
        if (gas_seen && stab_ms >= gdcs_pkg::STABLE_MS) begin
          cap_span = 1'b1;
          next_st = gdcs_pkg::S_LOW_WAIT;
        end
      end
      gdcs_pkg::S_REP_SPAN: begin
        if (reed_go) begin
          cap_span = 1'b1;
          finish = o2;
          next_st = o2 ? gdcs_pkg::S_IDLE : gdcs_pkg::S_LOW_WAIT;
        end
      end
      gdcs_pkg::S_LOW_WAIT: begin
        if (adc_hold < gdcs_pkg::LOW_THRESH) begin
          finish = 1'b1;
          next_st = gdcs_pkg::S_IDLE;
        end
      end
      gdcs_pkg::S_O2_PRE: begin
        if (phase_ms >= gdcs_pkg::O2_WAIT_MS) begin
          cap_span = 1'b1;
          next_st = gdcs_pkg::S_O2_POST;
        end
      end
      gdcs_pkg::S_O2_POST: begin
        if (phase_ms >= gdcs_pkg::O2_WAIT_MS) begin
          finish = 1'b1;
          next_st = gdcs_pkg::S_IDLE;
        end
      end
      default: next_st = gdcs_pkg::S_IDLE;
    endcase
    if (btn_rise) begin
      next_st = (sensor_type == gdcs_pkg::SENS_OPTICAL) ? gdcs_pkg::S_ZERO_STEADY :
                gdcs_pkg::S_REP_ZERO;
      cap_zero = 1'b0;
      cap_span = 1'b0;
      finish = 1'b0;
    end else if (abort_hit) begin
      next_st = gdcs_pkg::S_IDLE;
      cap_zero = 1'b0;
      cap_span = 1'b0;
      finish = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st <= gdcs_pkg::S_IDLE;
      rep_mode <= 1'b0;
      abort_flash <= 1'b0;
      zero_val <= 12'h000;
      span_val <= 12'h000;
      prev_zero <= 12'h000;
      prev_span <= 12'h000;
    end else begin
      st <= next_st;
      if (btn_rise) begin
        rep_mode <= 1'b1;
        abort_flash <= 1'b0;
        zero_val <= (st != gdcs_pkg::S_IDLE) ? prev_zero : zero_val;
        span_val <= (st != gdcs_pkg::S_IDLE) ? prev_span : span_val;
        prev_zero <= (st != gdcs_pkg::S_IDLE) ? prev_zero : zero_val;
        prev_span <= (st != gdcs_pkg::S_IDLE) ? prev_span : span_val;
      end else if (abort_hit) begin
        zero_val <= prev_zero;
        span_val <= prev_span;
        abort_flash <= 1'b1;
      end else begin
        if (start) begin
          prev_zero <= zero_val;
          prev_span <= span_val;
          abort_flash <= 1'b0;
        end
        if (cap_zero) begin
          zero_val <= adc_hold;
        end
        if (cap_span) begin
          span_val <= adc_hold;
        end
        if (finish) begin
          rep_mode <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || st == gdcs_pkg::S_IDLE || rep_mode) begin
      abort_ms <= 20'h0;
    end else if (tick && abort_ms != gdcs_pkg::ABORT_MS) begin
      abort_ms <= 20'(abort_ms + 20'h1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || next_st != st) begin
      phase_ms <= 20'h0;
    end else if (tick && phase_ms != gdcs_pkg::O2_WAIT_MS) begin
      phase_ms <= 20'(phase_ms + 20'h1);
    end
  end

  // ****************************************************************
  // indicators, fault and log feed
  // ****************************************************************
  logic next_cal_led;
  logic next_red_led;
  logic next_fault;
  assign next_cal_led =
    (st == gdcs_pkg::S_ZERO_STEADY || st == gdcs_pkg::S_REP_ZERO ||
     st == gdcs_pkg::S_O2_PRE) ? blink :
    (st == gdcs_pkg::S_SPAN_WAIT || st == gdcs_pkg::S_REP_SPAN) ?
      (gas_seen ? blink : 1'b1) :
    (st == gdcs_pkg::S_LOW_WAIT || st == gdcs_pkg::S_O2_POST);
  assign next_red_led = (red_win || abort_flash) && blink;
  assign next_fault = adc_hold < gdcs_pkg::FAULT_THRESH && !rep_mode;

  assign lg.wr = finish || abort_hit;
  assign lg.clr = finish && rep_mode;
  assign lg.zero = abort_hit ? 12'h000 : zero_val;
  assign lg.span = abort_hit ? 12'h000 : cap_span ? adc_hold : span_val;
  assign lg.stamp = stamp;
  assign lg.rd_idx = log_rd_idx;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      red_led <= 1'b0;
      cal_led <= 1'b0;
      fault <= 1'b0;
      cal_active <= 1'b0;
      cal_done <= 1'b0;
      cal_abort <= 1'b0;
      log_rd_zero <= 12'h000;
      log_rd_span <= 12'h000;
      log_rd_stamp <= 32'h0;
      log_count <= 4'h0;
    end else begin
      red_led <= next_red_led;
      cal_led <= next_cal_led;
      fault <= next_fault;
      cal_active <= next_st != gdcs_pkg::S_IDLE;
      cal_done <= finish;
      cal_abort <= abort_hit;
      log_rd_zero <= lg.rd_zero;
      log_rd_span <= lg.rd_span;
      log_rd_stamp <= lg.rd_stamp;
      log_count <= lg.count;
    end
  end

  gdcs_cal_log u_log (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .lg(lg)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_start_hold;
    $rose(cal_active) |-> $past(reed_ms) == 20'(gdcs_pkg::HOLD_MS - 20'h1) || $past(btn_rise);
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("calibration began without a full reed hold");

  property p_zero_cap;
    st == gdcs_pkg::S_ZERO_STEADY && stab_ms >= gdcs_pkg::ZERO_STEADY_MS && !btn_rise &&
    !abort_hit |=> zero_val == $past(adc_hold) && st == gdcs_pkg::S_SPAN_WAIT;
  endproperty
  a_zero_cap: assert property (p_zero_cap)
    else $error("steady zero not captured");

  property p_gas_flash;
    st == gdcs_pkg::S_SPAN_WAIT && gas_seen && blink |=> cal_led;
  endproperty
  a_gas_flash: assert property (p_gas_flash)
    else $error("calibrate indicator dark while gas seen");

  property p_span_stable;
    st == gdcs_pkg::S_SPAN_WAIT ##1 st == gdcs_pkg::S_LOW_WAIT |->
      $past(stab_ms) >= gdcs_pkg::STABLE_MS && span_val == $past(adc_hold);
  endproperty
  a_span_stable: assert property (p_span_stable)
    else $error("span captured before input stable");

  property p_low_done;
    st == gdcs_pkg::S_LOW_WAIT && adc_hold < gdcs_pkg::LOW_THRESH && !btn_rise &&
    !abort_hit |=> cal_done ##1 !cal_led;
  endproperty
  a_low_done: assert property (p_low_done)
    else $error("low input did not finish calibration");

  property p_abort_restore;
    abort_hit && !btn_rise |=> zero_val == $past(prev_zero) && span_val == $past(prev_span)
      && cal_abort && st == gdcs_pkg::S_IDLE;
  endproperty
  a_abort_restore: assert property (p_abort_restore)
    else $error("timeout abort did not restore values");

  property p_fault_quiet;
    rep_mode |=> !fault;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet)
    else $error("fault raised in replacement mode");

  property p_no_timeout;
    rep_mode |-> !abort_hit;
  endproperty
  a_no_timeout: assert property (p_no_timeout)
    else $error("replacement calibration timed out");

  property p_restart;
    btn_rise |=> rep_mode && (st == gdcs_pkg::S_REP_ZERO || st == gdcs_pkg::S_ZERO_STEADY);
  endproperty
  a_restart: assert property (p_restart)
    else $error("button did not restart at zero step");
endmodule : gdcs_sequencer

// File: dv/gdcs_field_model.sv
/*
 * field side model: gas sensor input and operator switches.
 * assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps
module gdcs_field_model (
  input wire logic core_clk,
  output logic [11:0] adc_sample,
  output logic adc_valid,
  output logic reed_sw,
  output logic replace_btn
);
  initial begin
    adc_sample = 12'h000;
    adc_valid = 1'b1;
    reed_sw = 1'b0;
    replace_btn = 1'b0;
  end
  // ****************************************************************
  // operator and sensor actions
  // ****************************************************************
  task automatic gas(input logic [11:0] v);
    adc_sample = v;
  endtask : gas
  task automatic set_reed(input logic v);
    reed_sw = v;
  endtask : set_reed
  task automatic set_valid(input logic v);
    adc_valid = v;
  endtask : set_valid
  task automatic press();
    replace_btn = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 replace_btn = 1'b0;
  endtask : press
endmodule : gdcs_field_model

// File: dv/tb_top.sv
/*
 * self-checking bench for the calibration sequencer.
 * assumes the field model drives sensor and switches; tick of one cycle.
 */
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] adc_sample;
  logic adc_valid, reed_sw, replace_btn;
  gdcs_pkg::gdcs_sensor_t sensor_type = gdcs_pkg::SENS_COMB;
  logic [11:0] stab_tol = 12'h004;
  logic [31:0] stamp = 32'h00001111;
  logic [2:0] log_rd_idx = 3'h0;
  logic red_led, cal_led, fault, cal_active, cal_done, cal_abort;
  logic [11:0] zero_val, span_val, log_rd_zero, log_rd_span;
  logic [31:0] log_rd_stamp;
  logic [3:0] log_count;
  int error_cnt = 0;
  int samples_checked = 0;
  always #2 core_clk = ~core_clk;
  gdcs_field_model f (.core_clk(core_clk), .adc_sample(adc_sample), .adc_valid(adc_valid),
    .reed_sw(reed_sw), .replace_btn(replace_btn));
  gdcs_sequencer #(.TICK_DIV(1)) dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .adc_sample(adc_sample), .adc_valid(adc_valid), .reed_sw(reed_sw),
    .replace_btn(replace_btn), .sensor_type(sensor_type), .stab_tol(stab_tol),
    .stamp(stamp), .log_rd_idx(log_rd_idx), .red_led(red_led), .cal_led(cal_led),
    .fault(fault), .zero_val(zero_val), .span_val(span_val), .cal_active(cal_active),
    .cal_done(cal_done), .cal_abort(cal_abort), .log_rd_zero(log_rd_zero),
    .log_rd_span(log_rd_span), .log_rd_stamp(log_rd_stamp), .log_count(log_count));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  // sel 0 zero_val, 1 span_val, 2 cal_done
  task automatic wait_sig(input int sel, input logic [11:0] exp, input int bound);
    logic [11:0] got;
    got = 12'h000;
    for (int i = 0; i < bound; i++) begin
      got = (sel == 0) ? zero_val : (sel == 1) ? span_val : {11'h000, cal_done};
      if (got === exp) break;
      cyc(1);
    end
    chk(got, exp);
    if (got !== exp) summarize();
  endtask : wait_sig
  // indicator must take both levels within n cycles
  task automatic blink(input int n);
    logic seen0, seen1;
    seen0 = 1'b0;
    seen1 = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (cal_led === 1'b0) seen0 = 1'b1;
      if (cal_led === 1'b1) seen1 = 1'b1;
      cyc(1);
    end
    chk({seen0, seen1}, 2'b11);
  endtask : blink
  // indicator must stay lit for n cycles
  task automatic steady(input int n);
    logic low_seen;
    low_seen = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (cal_led !== 1'b1) low_seen = 1'b1;
      cyc(1);
    end
    chk(low_seen, 1'b0);
  endtask : steady
  // v is applied just before the hold completes, so stability restarts if v leaves the tolerance band
  task automatic start_cal(input logic [11:0] v);
    logic red_seen;
    red_seen = 1'b0;
    f.set_reed(1'b1);
    for (int i = 0; i < 3990; i++) begin
      if (red_led === 1'b1) red_seen = 1'b1;
      cyc(1);
    end
    chk(cal_active, 1'b0);
    chk(red_seen, 1'b1);
    f.gas(v);
    cyc(30);
    chk(cal_active, 1'b1);
    f.set_reed(1'b0);
  endtask : start_cal
  task automatic reed_hold();
    f.set_reed(1'b1);
    cyc(4020);
    f.set_reed(1'b0);
    cyc(3);
  endtask : reed_hold
  task automatic chk_log(input logic [2:0] i, input logic [11:0] z, input logic [11:0] s,
                         input logic [31:0] t);
    log_rd_idx = i;
    cyc(3);
    chk(log_rd_zero, z);
    chk(log_rd_span, s);
    chk(log_rd_stamp, t);
  endtask : chk_log
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic sc_reset();
    chk({red_led, cal_led, cal_active, cal_done, cal_abort}, 5'h00);
    chk(log_count, 4'h0);
  endtask : sc_reset
  task automatic sc_routine();
    f.gas(12'h0F0);
    start_cal(12'h100);
    blink(600);
    wait_sig(0, 12'h100, 4300);
    cyc(3);
    chk(cal_led, 1'b1);
    stab_tol = 12'h010;
    f.gas(12'h108);
    cyc(3);
    steady(300);
    f.gas(12'h800);
    blink(600);
    wait_sig(1, 12'h800, 30600);
    cyc(3);
    chk(cal_led, 1'b1);
    chk(cal_active, 1'b1);
    f.gas(12'h050);
    wait_sig(2, 12'h001, 50);
    cyc(2);
    chk({cal_led, cal_active}, 2'b00);
    chk(log_count, 4'h1);
    chk_log(3'h0, 12'h100, 12'h800, 32'h00001111);
  endtask : sc_routine
  task automatic sc_o2();
    sensor_type = gdcs_pkg::SENS_O2;
    stamp = 32'h00002222;
    f.gas(12'h600);
    start_cal(12'h600);
    blink(600);
    cyc(2300);
    chk(span_val, 12'h800);
    wait_sig(1, 12'h600, 300);
    cyc(3);
    steady(2890);
    chk(cal_active, 1'b1);
    wait_sig(2, 12'h001, 300);
    cyc(2);
    chk(log_count, 4'h2);
    chk_log(3'h1, 12'h100, 12'h600, 32'h00002222);
  endtask : sc_o2
  task automatic sc_fault_idle();
    f.set_valid(1'b0);
    f.gas(12'h000);
    cyc(5);
    chk(fault, 1'b0);
    f.set_valid(1'b1);
    cyc(5);
    chk(fault, 1'b1);
  endtask : sc_fault_idle
  task automatic sc_replace();
    sensor_type = gdcs_pkg::SENS_TOXIC;
    stamp = 32'h00003333;
    f.press();
    cyc(5);
    chk(fault, 1'b0);
    chk(cal_active, 1'b1);
    blink(600);
    f.gas(12'h0C8);
    reed_hold();
    chk(zero_val, 12'h0C8);
    f.press();
    cyc(5);
    chk(zero_val, 12'h100);
    reed_hold();
    chk(zero_val, 12'h0C8);
    f.gas(12'h900);
    blink(600);
    chk(span_val, 12'h600);
    reed_hold();
    chk(span_val, 12'h900);
    f.gas(12'h050);
    wait_sig(2, 12'h001, 50);
    cyc(2);
    chk(log_count, 4'h1);
    chk_log(3'h0, 12'h0C8, 12'h900, 32'h00003333);
  endtask : sc_replace
  initial begin
    cyc(5);
    rst_b = 1'b1;
    cyc(2);
    sc_reset();
    sc_routine();
    sc_o2();
    sc_fault_idle();
    sc_replace();
    summarize();
  end
endmodule : tb_top
